// ===== verilog/olsm_pkg.sv
// package: register map, field layouts, source codes and sizes for the line source mux
package olsm_pkg;

   localparam int OLSM_LINES = 4;
   localparam int OLSM_SOFT_BITS = 8;
   localparam int OLSM_UNITS = 4;
   localparam int OLSM_STREAMS = 2;
   localparam int OLSM_LINE_IDX_W = 2;
   localparam int OLSM_SOFT_IDX_W = 3;
   localparam int OLSM_CHOICE_W = 7;
   localparam int OLSM_KIND_W = 3;
   localparam int OLSM_SYNC_STAGES = 2;

   // byte offsets of the registers
   localparam logic [11:0] OLSM_OFF_PIN_INDEX_PICK = 12'h000;
   localparam logic [11:0] OLSM_OFF_LINE_CFG = 12'h004;
   localparam logic [11:0] OLSM_OFF_SOFT_BIT_PICK = 12'h008;
   localparam logic [11:0] OLSM_OFF_SOFT_BIT_LEVEL = 12'h00C;
   localparam logic [11:0] OLSM_OFF_SOFT_BITS_WORD = 12'h010;
   localparam logic [11:0] OLSM_OFF_SOFT_BITS_WRITE_MASK = 12'h014;
   localparam logic [11:0] OLSM_OFF_PIN_LEVELS = 12'h018;

   // line configuration word fields
   localparam int OLSM_CFG_CHOICE_LSB = 0;
   localparam int OLSM_CFG_DIR_BIT = 8;
   localparam int OLSM_CFG_FLIP_BIT = 9;
   localparam int OLSM_CFG_KIND_LSB = 12;

   // reset values
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_RST_CHOICE = 7'h00;
   localparam logic [OLSM_KIND_W-1:0] OLSM_RST_KIND = 3'h2;
   localparam logic [OLSM_SOFT_BITS-1:0] OLSM_RST_SOFT_BITS = 8'h00;
   localparam logic [OLSM_SOFT_BITS-1:0] OLSM_RST_WRITE_MASK = 8'hFF;

   // source choice encoding; indexed groups take the base plus the soft bit, unit or stream index
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_OFF = 7'h00;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_SOFT_BASE = 7'h08;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ACQ_PENDING = 7'h10;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ACQ_TRIG = 7'h11;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ACQ_LOST = 7'h12;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ACQ_RUNNING = 7'h13;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_FRAME_PENDING = 7'h14;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_FRAME_TRIG = 7'h15;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_FRAME_LOST = 7'h16;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_FRAME_ON = 7'h17;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_EXPOSING = 7'h18;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ROW_PENDING = 7'h19;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ROW_TRIG = 7'h1A;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ROW_LOST = 7'h1B;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ROW_ON = 7'h1C;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_TALLY_BASE = 7'h20;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_DELAY_BASE = 7'h28;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_ENC_BASE = 7'h30;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_LOGIC_BASE = 7'h38;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_SWSIG_BASE = 7'h40;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_XFER_ACT_BASE = 7'h48;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_XFER_PAUSE_BASE = 7'h4C;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_XFER_STOPPING_BASE = 7'h50;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_XFER_STOPPED_BASE = 7'h54;
   localparam logic [OLSM_CHOICE_W-1:0] OLSM_SRC_XFER_OVERRUN_BASE = 7'h58;

   // electrical kinds of a line
   typedef enum logic [OLSM_KIND_W-1:0] {
      OLSM_KIND_UNWIRED = 3'h0,
      OLSM_KIND_TRISTATE = 3'h1,
      OLSM_KIND_TTL = 3'h2,
      OLSM_KIND_LVDS = 3'h3,
      OLSM_KIND_RS422 = 3'h4,
      OLSM_KIND_OPTO = 3'h5,
      OLSM_KIND_OPEN_DRAIN = 3'h6
   } olsm_kind_e;

   // only these kinds are settable; a write of another kind is refused and the stored kind is kept
   localparam logic [7:0] OLSM_KIND_SETTABLE = 8'h44;

endpackage

// ===== verilog/olsm_line_slot.sv
// one line slot: stored settings, source pick, polarity and driver enable
`timescale 1ns/1ns
module olsm_line_slot
   import olsm_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic cfg_we, // write strobe for this line's settings
   input wire logic [OLSM_CHOICE_W-1:0] choice_in, // new source choice
   input wire logic dir_in, // new direction, 1 output
   input wire logic flip_in, // new polarity flip
   input wire logic [OLSM_KIND_W-1:0] kind_in, // new electrical kind
   input wire logic [127:0] src_vec, // all sources, indexed by choice code
   input wire logic pin_sync, // synchronised pin level
   output logic [OLSM_CHOICE_W-1:0] pin_drive_choice, // stored source choice
   output logic pin_direction, // stored direction
   output logic pin_polarity_flip, // stored polarity flip
   output logic [OLSM_KIND_W-1:0] pin_electrical_kind, // stored kind
   output logic pin_o, // pin drive level
   output logic pin_oe_n, // pin driver enable, low drives
   output logic pin_status // line level after the inverter
);

   logic [OLSM_CHOICE_W-1:0] choice_r, choice_nxt;
   logic dir_r, dir_nxt;
   logic flip_r, flip_nxt;
   logic [OLSM_KIND_W-1:0] kind_r, kind_nxt;
   logic drive_r, drive_nxt;
   logic oe_n_r, oe_n_nxt;
   logic stat_r, stat_nxt;

   always_comb begin
      choice_nxt = choice_r;
      dir_nxt = dir_r;
      flip_nxt = flip_r;
      kind_nxt = kind_r;
      if (cfg_we) begin
         choice_nxt = choice_in;
         dir_nxt = dir_in;
         flip_nxt = flip_in;
         if (OLSM_KIND_SETTABLE[kind_in]) begin
            kind_nxt = kind_in;
         end
      end
      drive_nxt = src_vec[choice_r] ^ flip_r;
      // input mode or off choice keeps the driver released
      oe_n_nxt = ~dir_r | (choice_r == OLSM_SRC_OFF);
      stat_nxt = (dir_r ? drive_r : pin_sync ^ flip_r);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         choice_r <= OLSM_RST_CHOICE;
         dir_r <= 1'b0;
         flip_r <= 1'b0;
         kind_r <= OLSM_RST_KIND;
         drive_r <= 1'b0;
         oe_n_r <= 1'b1;
         stat_r <= 1'b0;
      end else begin
         choice_r <= choice_nxt;
         dir_r <= dir_nxt;
         flip_r <= flip_nxt;
         kind_r <= kind_nxt;
         drive_r <= drive_nxt;
         oe_n_r <= oe_n_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign pin_drive_choice = choice_r;
   assign pin_direction = dir_r;
   assign pin_polarity_flip = flip_r;
   assign pin_electrical_kind = kind_r;
   assign pin_o = drive_r;
   assign pin_oe_n = oe_n_r;
   assign pin_status = stat_r;

   AST_INPUT_RELEASES: assert property (@(posedge clk) disable iff (rst)
      !dir_r |=> pin_oe_n) else $error("input line driver not released");
   AST_OFF_RELEASES: assert property (@(posedge clk) disable iff (rst)
      choice_r == OLSM_SRC_OFF |=> pin_oe_n) else $error("off choice still drives");
   AST_DRIVE_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
      dir_r && $stable(choice_r) && $stable(flip_r) && choice_r != OLSM_SRC_OFF
      |=> !pin_oe_n && pin_o == ($past(src_vec[choice_r]) ^ $past(flip_r)))
      else $error("pin not following chosen source");
   AST_RESET_INPUT: assert property (@(posedge clk)
      $past(rst) |-> !dir_r && pin_oe_n) else $error("line not input after reset");

endmodule

// ===== verilog/olsm_top.sv
// top: apb register file, soft bit register, source vector and line slots
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module olsm_top
   import olsm_pkg::*;
#(
   parameter bit HAS_WRITE_MASK = 1'b1 // mask register present
)
(
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, 1 write
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic acq_start_pending, // acquisition waiting for start trigger
   input wire logic acq_running, // acquisition in progress
   input wire logic acq_start_trig, // acquisition start trigger arriving
   input wire logic acq_start_lost, // acquisition start trigger missed
   input wire logic frame_start_pending, // waiting for frame start trigger
   input wire logic frame_start_trig, // frame start trigger arriving
   input wire logic frame_start_lost, // frame start trigger missed
   input wire logic frame_capture_on, // frame capture in progress
   input wire logic row_start_pending, // waiting for row start trigger
   input wire logic row_start_trig, // row start trigger arriving
   input wire logic row_start_lost, // row start trigger missed
   input wire logic row_capture_on, // row capture in progress
   input wire logic exposing_now, // frame or row exposure
   input wire logic [OLSM_UNITS-1:0] tally_running, // counters counting
   input wire logic [OLSM_UNITS-1:0] delay_running, // timers active
   input wire logic [OLSM_UNITS-1:0] encoder_out, // encoder outputs
   input wire logic [OLSM_UNITS-1:0] logic_block_out, // logic block outputs
   input wire logic [OLSM_UNITS-1:0] soft_signal_out, // software signal outputs
   input wire logic [OLSM_STREAMS-1:0] stream_active, // stream transfer active
   input wire logic [OLSM_STREAMS-1:0] stream_paused, // stream transfer paused
   input wire logic [OLSM_STREAMS-1:0] stream_stopping, // stream transfer stopping
   input wire logic [OLSM_STREAMS-1:0] stream_stopped, // stream transfer stopped
   input wire logic [OLSM_STREAMS-1:0] stream_overrun, // stream transfer overflow
   input wire logic [OLSM_LINES-1:0] line_i, // pin levels seen from outside
   output logic [OLSM_LINES-1:0] line_o, // pin drive levels
   output logic [OLSM_LINES-1:0] line_oe_n, // pin driver enables, low drives
   output logic [OLSM_SOFT_BITS-1:0] soft_bits // soft bit register
);

   logic [OLSM_LINE_IDX_W-1:0] pick_r, pick_nxt;
   logic [OLSM_SOFT_IDX_W-1:0] bit_pick_r, bit_pick_nxt;
   logic [OLSM_SOFT_BITS-1:0] bits_r, bits_nxt;
   logic [OLSM_SOFT_BITS-1:0] mask_r, mask_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;
   logic [OLSM_LINES-1:0] sync1_r, sync2_r;
   logic [127:0] src_vec;
   logic wr, rd, hit;
   logic [OLSM_LINES-1:0] cfg_we;
   logic [OLSM_CHOICE_W-1:0] choice [OLSM_LINES];
   logic [OLSM_LINES-1:0] dir, flip, stat;
   logic [OLSM_KIND_W-1:0] kind [OLSM_LINES];
   logic [OLSM_SOFT_BITS-1:0] word_mask;

   // pins arrive from outside, two flops before any use
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= line_i;
         sync2_r <= sync1_r;
      end
   end

   // source vector indexed directly by choice code
   always_comb begin
      src_vec = '0;
      for (int i = 0; i < OLSM_SOFT_BITS; i++) begin
         src_vec[OLSM_SRC_SOFT_BASE + i] = bits_r[i];
      end
      src_vec[OLSM_SRC_ACQ_PENDING] = acq_start_pending;
      src_vec[OLSM_SRC_ACQ_TRIG] = acq_start_trig;
      src_vec[OLSM_SRC_ACQ_LOST] = acq_start_lost;
      src_vec[OLSM_SRC_ACQ_RUNNING] = acq_running;
      src_vec[OLSM_SRC_FRAME_PENDING] = frame_start_pending;
      src_vec[OLSM_SRC_FRAME_TRIG] = frame_start_trig;
      src_vec[OLSM_SRC_FRAME_LOST] = frame_start_lost;
      src_vec[OLSM_SRC_FRAME_ON] = frame_capture_on;
      src_vec[OLSM_SRC_EXPOSING] = exposing_now;
      src_vec[OLSM_SRC_ROW_PENDING] = row_start_pending;
      src_vec[OLSM_SRC_ROW_TRIG] = row_start_trig;
      src_vec[OLSM_SRC_ROW_LOST] = row_start_lost;
      src_vec[OLSM_SRC_ROW_ON] = row_capture_on;
      for (int u = 0; u < OLSM_UNITS; u++) begin
         src_vec[OLSM_SRC_TALLY_BASE + u] = tally_running[u];
         src_vec[OLSM_SRC_DELAY_BASE + u] = delay_running[u];
         src_vec[OLSM_SRC_ENC_BASE + u] = encoder_out[u];
         src_vec[OLSM_SRC_LOGIC_BASE + u] = logic_block_out[u];
         src_vec[OLSM_SRC_SWSIG_BASE + u] = soft_signal_out[u];
      end
      for (int s = 0; s < OLSM_STREAMS; s++) begin
         src_vec[OLSM_SRC_XFER_ACT_BASE + s] = stream_active[s];
         src_vec[OLSM_SRC_XFER_PAUSE_BASE + s] = stream_paused[s];
         src_vec[OLSM_SRC_XFER_STOPPING_BASE + s] = stream_stopping[s];
         src_vec[OLSM_SRC_XFER_STOPPED_BASE + s] = stream_stopped[s];
         src_vec[OLSM_SRC_XFER_OVERRUN_BASE + s] = stream_overrun[s];
      end
   end

   // zero-wait slave: every access completes in its first access cycle
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = err_r & penable;
   assign prdata = rdata_r;

   assign hit = (paddr == OLSM_OFF_PIN_INDEX_PICK) || (paddr == OLSM_OFF_LINE_CFG) ||
      (paddr == OLSM_OFF_SOFT_BIT_PICK) || (paddr == OLSM_OFF_SOFT_BIT_LEVEL) ||
      (paddr == OLSM_OFF_SOFT_BITS_WORD) || (paddr == OLSM_OFF_SOFT_BITS_WRITE_MASK) ||
      (paddr == OLSM_OFF_PIN_LEVELS);

   // without a mask every bit is written
   assign word_mask = HAS_WRITE_MASK ? mask_r : {OLSM_SOFT_BITS{1'b1}};

   always_comb begin
      pick_nxt = pick_r;
      bit_pick_nxt = bit_pick_r;
      bits_nxt = bits_r;
      mask_nxt = mask_r;
      cfg_we = '0;
      if (wr) begin
         case (paddr)
            OLSM_OFF_PIN_INDEX_PICK: begin
               pick_nxt = pwdata[OLSM_LINE_IDX_W-1:0];
            end
            OLSM_OFF_LINE_CFG: begin
               cfg_we[pick_r] = 1'b1;
            end
            OLSM_OFF_SOFT_BIT_PICK: begin
               bit_pick_nxt = pwdata[OLSM_SOFT_IDX_W-1:0];
            end
            OLSM_OFF_SOFT_BIT_LEVEL: begin
               bits_nxt[bit_pick_r] = pwdata[0];
            end
            OLSM_OFF_SOFT_BITS_WORD: begin
               // bit i of the word lands on soft bit i
               bits_nxt = (bits_r & ~word_mask) |
                  (pwdata[OLSM_SOFT_BITS-1:0] & word_mask);
            end
            OLSM_OFF_SOFT_BITS_WRITE_MASK: begin
               if (HAS_WRITE_MASK) begin
                  mask_nxt = pwdata[OLSM_SOFT_BITS-1:0];
               end
            end
            default: begin
               pick_nxt = pick_r;
            end
         endcase
      end
   end

   // read data captured in setup, so it stands through the access phase
   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt = 1'b0;
      if (psel & ~penable) begin
         err_nxt = ~hit;
      end else if (psel & penable) begin
         err_nxt = err_r;
      end
      if (rd) begin
         rdata_nxt = '0;
         case (paddr)
            OLSM_OFF_PIN_INDEX_PICK: begin
               rdata_nxt[OLSM_LINE_IDX_W-1:0] = pick_r;
            end
            OLSM_OFF_LINE_CFG: begin
               rdata_nxt[OLSM_CFG_CHOICE_LSB +: OLSM_CHOICE_W] = choice[pick_r];
               rdata_nxt[OLSM_CFG_DIR_BIT] = dir[pick_r];
               rdata_nxt[OLSM_CFG_FLIP_BIT] = flip[pick_r];
               rdata_nxt[OLSM_CFG_KIND_LSB +: OLSM_KIND_W] = kind[pick_r];
            end
            OLSM_OFF_SOFT_BIT_PICK: begin
               rdata_nxt[OLSM_SOFT_IDX_W-1:0] = bit_pick_r;
            end
            OLSM_OFF_SOFT_BIT_LEVEL: begin
               rdata_nxt[0] = bits_r[bit_pick_r];
            end
            OLSM_OFF_SOFT_BITS_WORD: begin
               rdata_nxt[OLSM_SOFT_BITS-1:0] = bits_r;
            end
            OLSM_OFF_SOFT_BITS_WRITE_MASK: begin
               rdata_nxt[OLSM_SOFT_BITS-1:0] = word_mask;
            end
            OLSM_OFF_PIN_LEVELS: begin
               rdata_nxt[OLSM_LINES-1:0] = stat;
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pick_r <= '0;
         bit_pick_r <= '0;
         bits_r <= OLSM_RST_SOFT_BITS;
         mask_r <= OLSM_RST_WRITE_MASK;
         rdata_r <= '0;
         err_r <= 1'b0;
      end else begin
         pick_r <= pick_nxt;
         bit_pick_r <= bit_pick_nxt;
         bits_r <= bits_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   assign soft_bits = bits_r;

   for (genvar g = 0; g < OLSM_LINES; g++) begin : g_line
      olsm_line_slot u_slot (
         .clk(clk),
         .rst(rst),
         .cfg_we(cfg_we[g]),
         .choice_in(pwdata[OLSM_CFG_CHOICE_LSB +: OLSM_CHOICE_W]),
         .dir_in(pwdata[OLSM_CFG_DIR_BIT]),
         .flip_in(pwdata[OLSM_CFG_FLIP_BIT]),
         .kind_in(pwdata[OLSM_CFG_KIND_LSB +: OLSM_KIND_W]),
         .src_vec(src_vec),
         .pin_sync(sync2_r[g]),
         .pin_drive_choice(choice[g]),
         .pin_direction(dir[g]),
         .pin_polarity_flip(flip[g]),
         .pin_electrical_kind(kind[g]),
         .pin_o(line_o[g]),
         .pin_oe_n(line_oe_n[g]),
         .pin_status(stat[g])
      );
   end

   AST_SINGLE_BIT_ONLY: assert property (@(posedge clk) disable iff (rst)
      wr && paddr == OLSM_OFF_SOFT_BIT_LEVEL
      |=> bits_r[$past(bit_pick_r)] == $past(pwdata[0]) &&
          ((bits_r ^ $past(bits_r)) & ~(8'h01 << $past(bit_pick_r))) == 8'h00)
      else $error("single bit write touched wrong bits");
   AST_SINGLE_IGNORES_MASK: assert property (@(posedge clk) disable iff (rst)
      wr && paddr == OLSM_OFF_SOFT_BIT_LEVEL && mask_r == 8'h00
      |=> bits_r[$past(bit_pick_r)] == $past(pwdata[0]))
      else $error("mask blocked single bit write");
   AST_WORD_MASKED: assert property (@(posedge clk) disable iff (rst)
      wr && paddr == OLSM_OFF_SOFT_BITS_WORD
      |=> ((bits_r ^ $past(bits_r)) & ~$past(word_mask)) == 8'h00 &&
          (bits_r & $past(word_mask)) == ($past(pwdata[7:0]) & $past(word_mask)))
      else $error("masked word write wrong");
   AST_PICK_TARGETS: assert property (@(posedge clk) disable iff (rst)
      wr && paddr == OLSM_OFF_SOFT_BIT_PICK |=> bit_pick_r == $past(pwdata[2:0]))
      else $error("picked soft bit not targeted");
   AST_SOFT_TRACKS: assert property (@(posedge clk) disable iff (rst)
      dir[0] && !flip[0] && choice[0][6:3] == 4'h1
      |=> line_o[0] == $past(bits_r[choice[0][2:0]]))
      else $error("line does not track soft bit");
   AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (rst)
      psel && !penable && !hit ##1 psel && penable |-> pslverr)
      else $error("unmapped address not flagged");

   COV_WORD_WRITE: cover property (@(posedge clk) wr && paddr == OLSM_OFF_SOFT_BITS_WORD);
   COV_LINE_DRIVES: cover property (@(posedge clk) !line_oe_n[0] ##1 line_oe_n[0]);
   COV_FLIPPED_OUT: cover property (@(posedge clk) flip[1] && !line_oe_n[1]);
   COV_BIT_WRITE: cover property (@(posedge clk) wr && paddr == OLSM_OFF_SOFT_BIT_LEVEL);

endmodule

// ===== verification/olsm_line_equip.sv
// external equipment model wired to the connector lines
`timescale 1ns/1ns
module olsm_line_equip
   import olsm_pkg::*;
(
   input wire logic [OLSM_LINES-1:0] line_o, // device drive levels
   input wire logic [OLSM_LINES-1:0] line_oe_n, // device enables, low drives
   input wire logic [OLSM_LINES-1:0] ext_drive, // equipment level on free lines
   output logic [OLSM_LINES-1:0] line_i // resolved wire level
);
   // equipment drives only released lines, so the wire never fights
   always_comb begin
      for (int i = 0; i < OLSM_LINES; i++) begin
         line_i[i] = line_oe_n[i] ? ext_drive[i] : line_o[i];
      end
   end
endmodule

// ===== verification/tb_olsm_top.sv
// self-checking testbench for the line source mux
`timescale 1ns/1ns
module tb_olsm_top;
   import olsm_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [42:0] src = '0;
   logic [3:0] line_i, line_o, line_oe_n, ext = 4'hA;
   logic [7:0] soft_bits;
   logic [6:0] codes[43];
   int errors = 0, samples_checked = 0, ln;
   always #2 clk = ~clk;
   olsm_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acq_start_pending(src[0]), .acq_start_trig(src[1]), .acq_start_lost(src[2]),
      .acq_running(src[3]), .frame_start_pending(src[4]), .frame_start_trig(src[5]),
      .frame_start_lost(src[6]), .frame_capture_on(src[7]), .exposing_now(src[8]),
      .row_start_pending(src[9]), .row_start_trig(src[10]), .row_start_lost(src[11]),
      .row_capture_on(src[12]), .tally_running(src[16:13]), .delay_running(src[20:17]),
      .encoder_out(src[24:21]), .logic_block_out(src[28:25]), .soft_signal_out(src[32:29]),
      .stream_active(src[34:33]), .stream_paused(src[36:35]), .stream_stopping(src[38:37]),
      .stream_stopped(src[40:39]), .stream_overrun(src[42:41]), .line_i(line_i),
      .line_o(line_o), .line_oe_n(line_oe_n), .soft_bits(soft_bits));
   olsm_line_equip u_equip (.line_o(line_o), .line_oe_n(line_oe_n), .ext_drive(ext),
      .line_i(line_i));
   function automatic logic [31:0] cfgw(logic [6:0] c, logic d, logic f, logic [2:0] k);
      return {17'h0, k, 2'b0, f, d, 1'b0, c};
   endfunction
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD t=%0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      finish_test;
   end
   initial begin
      // rows: codes[i] is the choice code that routes source bit i
      for (int i = 0; i < 13; i++) codes[i] = 7'h10 + 7'(i);
      for (int g = 0; g < 5; g++)
         for (int u = 0; u < 4; u++) codes[13+4*g+u] = 7'h20 + 7'(8*g+u);
      for (int k = 0; k < 5; k++)
         for (int s = 0; s < 2; s++) codes[33+2*k+s] = 7'h48 + 7'(4*k+s);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 43; i++) begin
         ln = i % 4;
         apb(1'b1, OLSM_OFF_PIN_INDEX_PICK, 32'(ln));
         apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(codes[i], 1'b1, 1'(i % 2), 3'h2));
         src <= 43'h1 << i;
         settle;
         chk(line_oe_n[ln] === 1'b0 && line_o[ln] === 1'(1 - i % 2), "source high");
         src <= ~(43'h1 << i);
         settle;
         chk(line_o[ln] === 1'(i % 2), "source low");
      end
      $display("source table done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      settle;
      chk(line_oe_n === 4'hF && soft_bits === 8'h00, "reset state");
      apb(1'b0, OLSM_OFF_LINE_CFG, 32'h0);
      chk(rd === 32'h0000_2000, "reset cfg");
      apb(1'b0, OLSM_OFF_PIN_LEVELS, 32'h0);
      chk(rd === 32'h0000_000A, "input levels");
      apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(7'h00, 1'b0, 1'b0, 3'h3));
      apb(1'b0, OLSM_OFF_LINE_CFG, 32'h0);
      chk(rd === 32'h0000_2000, "kind refused");
      apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(7'h00, 1'b1, 1'b0, 3'h6));
      apb(1'b0, OLSM_OFF_LINE_CFG, 32'h0);
      settle;
      chk(rd === 32'h0000_6100 && line_oe_n[0] === 1'b1, "kind set, off");
      src <= '1;
      apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(7'h18, 1'b0, 1'b0, 3'h2));
      settle;
      chk(line_oe_n[0] === 1'b1, "input released");
      apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(7'h18, 1'b0, 1'b1, 3'h2));
      apb(1'b0, OLSM_OFF_PIN_LEVELS, 32'h0);
      chk(rd === 32'h0000_000B && line_oe_n[0] === 1'b1, "input flipped");
      $display("line tests done");
      apb(1'b1, OLSM_OFF_SOFT_BITS_WRITE_MASK, 32'h0);
      apb(1'b1, OLSM_OFF_SOFT_BIT_PICK, 32'h5);
      apb(1'b1, OLSM_OFF_SOFT_BIT_LEVEL, 32'h1);
      settle;
      chk(soft_bits === 8'h20, "single bit");
      apb(1'b1, OLSM_OFF_SOFT_BITS_WRITE_MASK, 32'h0F);
      apb(1'b1, OLSM_OFF_SOFT_BITS_WORD, 32'hFF);
      settle;
      chk(soft_bits === 8'h2F, "masked word");
      apb(1'b1, OLSM_OFF_SOFT_BITS_WORD, 32'h01);
      apb(1'b1, OLSM_OFF_LINE_CFG, cfgw(7'h0D, 1'b1, 1'b0, 3'h2));
      settle;
      chk(soft_bits === 8'h21 && line_o[0] === 1'b1, "soft source");
      apb(1'b1, OLSM_OFF_SOFT_BIT_LEVEL, 32'h0);
      settle;
      chk(line_o[0] === 1'b0 && soft_bits === 8'h01, "soft tracks");
      apb(1'b0, 12'h020, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped");
      $display("soft bit tests done");
      finish_test;
   end
endmodule
